// ===== core/ata_cmd_pkg.sv
// Shared constants and types for the ATA command completion block
package ata_cmd_pkg;

	// Command opcodes handled here
	localparam logic [7:0] OP_READ_VERIFY = 8'h40;
	localparam logic [7:0] OP_READ_DMA = 8'hC8;
	localparam logic [7:0] OP_SET_MULTIPLE = 8'hC6;
	localparam logic [7:0] OP_SLEEP = 8'hE6;
	localparam logic [7:0] OP_FLUSH = 8'hE7;

	// Register selects on the host write port, in command block order
	localparam logic [3:0] SEL_FEATURE = 4'h1;
	localparam logic [3:0] SEL_COUNT = 4'h2;
	localparam logic [3:0] SEL_ADDR0 = 4'h3;
	localparam logic [3:0] SEL_ADDR1 = 4'h4;
	localparam logic [3:0] SEL_ADDR2 = 4'h5;
	localparam logic [3:0] SEL_DEVICE = 4'h6;
	localparam logic [3:0] SEL_COMMAND = 4'h7;

	// Status bit positions
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DF = 5;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;

	// Error bit positions
	localparam int ER_ICRC = 7;
	localparam int ER_UNC = 6;
	localparam int ER_IDNF = 4;
	localparam int ER_ABRT = 2;

	// Device register select bit
	localparam int DEV_BIT = 4;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h40;
	localparam logic [7:0] ERROR_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] BLOCK_RESET = 8'h01;

	// Only block size that the media supports
	localparam logic [7:0] BLOCK_SUPPORTED = 8'h01;

	// Sector count code zero stands for a full run of sectors
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [8:0] COUNT_FULL = 9'h100;
	localparam logic [8:0] COUNT_LAST = 9'h001;

	// Command block as seen by the host
	typedef struct packed {
		logic [7:0] error;
		logic [7:0] count;
		logic [7:0] addr0;
		logic [7:0] addr1;
		logic [7:0] addr2;
		logic [7:0] device;
		logic [7:0] status;
	} task_file_type;

	// Outcome of one sector read from the media
	typedef struct packed {
		logic unc;
		logic idnf;
		logic crc;
	} media_result_type;

endpackage

// ===== core/sector_walker.sv
// Sector address and remaining-count tracker for multi-sector reads
`timescale 1ns/10ps
module sector_walker #(
	parameter int ADDR_W = 28,
	parameter int CNT_W = 9
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic step,
	input wire logic [ADDR_W-1:0] start_addr,
	input wire logic [7:0] count_code,
	output logic [ADDR_W-1:0] addr_q,
	output logic [CNT_W-1:0] left_q,
	output logic last
);

	logic [CNT_W-1:0] load_count;

	// A zero code asks for the full run, anything else is literal
	assign load_count = (count_code == ata_cmd_pkg::COUNT_ZERO) ?
		CNT_W'(ata_cmd_pkg::COUNT_FULL) : CNT_W'(count_code);
	assign last = (left_q == CNT_W'(ata_cmd_pkg::COUNT_LAST));

	// Load wins over step so a new command never inherits an old address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			addr_q <= '0;
			left_q <= '0;
		end
		else if (load)
		begin
			addr_q <= start_addr;
			left_q <= load_count;
		end
		else if (step)
		begin
			addr_q <= addr_q + ADDR_W'(1);
			left_q <= left_q - CNT_W'(1);
		end
	end

endmodule

// ===== core/ata_command_completion.sv
// Device-side execution and completion status for a set of ATA commands
`timescale 1ns/10ps
module ata_command_completion (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [3:0] reg_sel,
	input wire logic [7:0] reg_wdata,
	output ata_cmd_pkg::task_file_type task_file,
	output logic [7:0] block_size,
	output logic sleep_mode,
	output logic media_req,
	output logic [27:0] media_addr,
	output logic media_to_host,
	input wire logic media_done,
	input wire ata_cmd_pkg::media_result_type media_result,
	input wire logic udma_mode,
	input wire logic dev_fault,
	output logic flush_req,
	input wire logic flush_done,
	input wire logic flush_fail,
	input wire logic [27:0] flush_addr,
	output logic dma_active
);

	typedef enum logic [1:0] {IDLE, ISSUE, WAIT, FLUSH} state_type;

	state_type state_q, state_d;
	ata_cmd_pkg::task_file_type tf_q, tf_d;
	logic [7:0] block_q, block_d;
	logic sleep_q, sleep_d;
	logic media_req_q, media_req_d;
	logic to_host_q, to_host_d;
	logic flush_req_q, flush_req_d;
	logic dma_q, dma_d;
	logic walker_load, walker_step;
	logic [8:0] sectors_left;
	logic last_sector;
	logic [7:0] err_v;

	// Error byte from individual causes
	function automatic logic [7:0] err_bits(input logic icrc, input logic unc,
		input logic idnf, input logic abrt);
		logic [7:0] e;
		e = 8'h00;
		e[ata_cmd_pkg::ER_ICRC] = icrc;
		e[ata_cmd_pkg::ER_UNC] = unc;
		e[ata_cmd_pkg::ER_IDNF] = idnf;
		e[ata_cmd_pkg::ER_ABRT] = abrt;
		return e;
	endfunction

	// Completion status: never busy, never DRQ, ready, fault and error as given
	function automatic logic [7:0] done_status(input logic df, input logic err);
		logic [7:0] s;
		s = 8'h00;
		s[ata_cmd_pkg::ST_DRDY] = 1'b1;
		s[ata_cmd_pkg::ST_DF] = df;
		s[ata_cmd_pkg::ST_ERR] = err;
		return s;
	endfunction

	// Status while a command runs
	function automatic logic [7:0] busy_status();
		logic [7:0] s;
		s = 8'h00;
		s[ata_cmd_pkg::ST_BSY] = 1'b1;
		s[ata_cmd_pkg::ST_DRDY] = 1'b1;
		return s;
	endfunction

	// Decoding of host accesses; writes are ignored while busy as on any ATA device
	wire logic busy = tf_q.status[ata_cmd_pkg::ST_BSY];
	wire logic reg_take = reg_wr && !busy;
	wire logic cmd_take = reg_take && (reg_sel == ata_cmd_pkg::SEL_COMMAND);
	wire logic [7:0] opcode = reg_wdata;
	wire logic [27:0] start_addr = {tf_q.device[3:0], tf_q.addr2, tf_q.addr1,
		tf_q.addr0};
	wire logic crc_err = media_result.crc && udma_mode && to_host_q;
	wire logic [7:0] media_err = err_bits(crc_err, media_result.unc,
		media_result.idnf, 1'b0);
	wire logic read_fails = media_done && (state_q == WAIT) &&
		((|media_err) || dev_fault);
	wire logic block_ok = (tf_q.count == ata_cmd_pkg::BLOCK_SUPPORTED);
	wire logic block_zero = (tf_q.count == ata_cmd_pkg::COUNT_ZERO);

	sector_walker #(
		.ADDR_W(28),
		.CNT_W(9)
	) walker (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(walker_load),
		.step(walker_step),
		.start_addr(start_addr),
		.count_code(tf_q.count),
		.addr_q(media_addr),
		.left_q(sectors_left),
		.last(last_sector)
	);

	// Command sequencing and completion reporting
	always_comb
	begin
		err_v = 8'h00;
		state_d = state_q;
		tf_d = tf_q;
		block_d = block_q;
		sleep_d = sleep_q;
		media_req_d = 1'b0;
		flush_req_d = 1'b0;
		to_host_d = to_host_q;
		dma_d = dma_q;
		walker_load = 1'b0;
		walker_step = 1'b0;
		if (reg_take)
		begin
			case (reg_sel)
				ata_cmd_pkg::SEL_COUNT: tf_d.count = reg_wdata;
				ata_cmd_pkg::SEL_ADDR0: tf_d.addr0 = reg_wdata;
				ata_cmd_pkg::SEL_ADDR1: tf_d.addr1 = reg_wdata;
				ata_cmd_pkg::SEL_ADDR2: tf_d.addr2 = reg_wdata;
				ata_cmd_pkg::SEL_DEVICE: tf_d.device = reg_wdata;
				default: tf_d.count = tf_d.count;
			endcase
		end
		case (state_q)
			IDLE:
			begin
				if (cmd_take)
				begin
					tf_d.error = 8'h00;
					tf_d.status = busy_status();
					case (opcode)
						ata_cmd_pkg::OP_READ_VERIFY, ata_cmd_pkg::OP_READ_DMA:
						begin
							walker_load = 1'b1;
							to_host_d = (opcode == ata_cmd_pkg::OP_READ_DMA);
							dma_d = (opcode == ata_cmd_pkg::OP_READ_DMA);
							state_d = ISSUE;
						end
						ata_cmd_pkg::OP_SET_MULTIPLE:
						begin
							// A refused size leaves the stored one alone
							if (block_ok)
								block_d = tf_q.count;
							err_v = err_bits(1'b0, 1'b0, 1'b0, !(block_ok || block_zero));
							tf_d.status = done_status(dev_fault, |err_v);
							tf_d.error = err_v;
						end
						ata_cmd_pkg::OP_SLEEP:
						begin
							sleep_d = 1'b1;
							tf_d.status = done_status(dev_fault, 1'b0);
						end
						ata_cmd_pkg::OP_FLUSH:
						begin
							flush_req_d = 1'b1;
							state_d = FLUSH;
						end
						default:
						begin
							err_v = err_bits(1'b0, 1'b0, 1'b0, 1'b1);
							tf_d.error = err_v;
							tf_d.status = done_status(dev_fault, 1'b1);
						end
					endcase
				end
			end
			ISSUE:
			begin
				media_req_d = 1'b1;
				state_d = WAIT;
			end
			WAIT:
			begin
				if (read_fails)
				begin
					// Stop at the first bad sector and leave its address for the host
					tf_d.error = media_err;
					tf_d.addr0 = media_addr[7:0];
					tf_d.addr1 = media_addr[15:8];
					tf_d.addr2 = media_addr[23:16];
					tf_d.device = {tf_q.device[7:4], media_addr[27:24]};
					tf_d.status = done_status(dev_fault, |media_err);
					dma_d = 1'b0;
					state_d = IDLE;
				end
				else if (media_done && last_sector)
				begin
					tf_d.status = done_status(1'b0, 1'b0);
					dma_d = 1'b0;
					state_d = IDLE;
				end
				else if (media_done)
				begin
					walker_step = 1'b1;
					state_d = ISSUE;
				end
			end
			FLUSH:
			begin
				// BSY stays up until the cache reports back
				if (flush_done)
				begin
					err_v = err_bits(1'b0, 1'b0, 1'b0, flush_fail);
					tf_d.error = err_v;
					if (flush_fail)
					begin
						tf_d.addr0 = flush_addr[7:0];
						tf_d.addr1 = flush_addr[15:8];
						tf_d.addr2 = flush_addr[23:16];
						tf_d.device = {tf_q.device[7:4], flush_addr[27:24]};
					end
					tf_d.status = done_status(dev_fault, |err_v);
					state_d = IDLE;
				end
			end
			default: state_d = IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= IDLE;
			tf_q <= '{ata_cmd_pkg::ERROR_RESET, ata_cmd_pkg::REG_RESET,
				ata_cmd_pkg::REG_RESET, ata_cmd_pkg::REG_RESET, ata_cmd_pkg::REG_RESET,
				ata_cmd_pkg::REG_RESET, ata_cmd_pkg::STATUS_RESET};
			block_q <= ata_cmd_pkg::BLOCK_RESET;
			sleep_q <= 1'b0;
			media_req_q <= 1'b0;
			to_host_q <= 1'b0;
			flush_req_q <= 1'b0;
			dma_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			tf_q <= tf_d;
			block_q <= block_d;
			sleep_q <= sleep_d;
			media_req_q <= media_req_d;
			to_host_q <= to_host_d;
			flush_req_q <= flush_req_d;
			dma_q <= dma_d;
		end
	end

	assign task_file = tf_q;
	assign block_size = block_q;
	assign sleep_mode = sleep_q;
	assign media_req = media_req_q;
	assign media_to_host = to_host_q;
	assign flush_req = flush_req_q;
	assign dma_active = dma_q;

	// Checks on the completion behaviour
	sequence s_cmd(logic [7:0] op);
		cmd_take && (opcode == op);
	endsequence

	sequence s_read_err;
		read_fails;
	endsequence

	property p_no_drq;
		@(posedge clk) disable iff (sys_rst)
		!tf_q.status[ata_cmd_pkg::ST_DRQ] && (!media_req_q || dma_q || !to_host_q);
	endproperty
	a_no_drq: assert property (p_no_drq) else $error("DRQ raised");

	property p_err_addr;
		@(posedge clk) disable iff (sys_rst)
		s_read_err |=> ({tf_q.device[3:0], tf_q.addr2, tf_q.addr1, tf_q.addr0}
		== $past(media_addr)) && (tf_q.device[7:4] == $past(tf_q.device[7:4]));
	endproperty
	a_err_addr: assert property (p_err_addr) else $error("Bad failing address");

	property p_unc_idnf;
		@(posedge clk) disable iff (sys_rst)
		s_read_err |=> (tf_q.error[ata_cmd_pkg::ER_UNC] == $past(media_result.unc))
		&& (tf_q.error[ata_cmd_pkg::ER_IDNF] == $past(media_result.idnf));
	endproperty
	a_unc_idnf: assert property (p_unc_idnf) else $error("UNC or IDNF wrong");

	property p_err_status;
		@(posedge clk) disable iff (sys_rst)
		s_read_err |=> !tf_q.status[ata_cmd_pkg::ST_BSY] &&
		tf_q.status[ata_cmd_pkg::ST_DRDY] && !tf_q.status[ata_cmd_pkg::ST_DRQ] &&
		(tf_q.status[ata_cmd_pkg::ST_ERR] == (|tf_q.error)) && !dma_q;
	endproperty
	a_err_status: assert property (p_err_status) else $error("Bad error status");

	property p_ok_status;
		@(posedge clk) disable iff (sys_rst)
		(state_q == WAIT) && media_done && !read_fails && last_sector |=>
		(tf_q.status == done_status(1'b0, 1'b0)) ##1 (state_q == IDLE);
	endproperty
	a_ok_status: assert property (p_ok_status) else $error("Bad good status");

	property p_dma_read;
		@(posedge clk) disable iff (sys_rst)
		s_cmd(ata_cmd_pkg::OP_READ_DMA) |=> dma_q && to_host_q && busy ##1
		media_req_q;
	endproperty
	a_dma_read: assert property (p_dma_read) else $error("DMA read not started");

	property p_full_count;
		@(posedge clk) disable iff (sys_rst)
		cmd_take && ((opcode == ata_cmd_pkg::OP_READ_VERIFY) ||
		(opcode == ata_cmd_pkg::OP_READ_DMA)) && (tf_q.count == ata_cmd_pkg::COUNT_ZERO) |=>
		(sectors_left == ata_cmd_pkg::COUNT_FULL) && (to_host_q == dma_q);
	endproperty
	a_full_count: assert property (p_full_count) else $error("Count zero wrong");

	property p_block_size;
		@(posedge clk) disable iff (sys_rst)
		s_cmd(ata_cmd_pkg::OP_SET_MULTIPLE) and (tf_q.count > 8'h01) |=>
		(block_q == $past(block_q)) && tf_q.error[ata_cmd_pkg::ER_ABRT] &&
		tf_q.status[ata_cmd_pkg::ST_ERR];
	endproperty
	a_block_size: assert property (p_block_size) else $error("Bad size accepted");

	property p_sleep_entry;
		@(posedge clk) disable iff (sys_rst)
		$rose(sleep_q) |-> $past(cmd_take && (opcode == ata_cmd_pkg::OP_SLEEP)) &&
		!tf_q.status[ata_cmd_pkg::ST_ERR] && !busy;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entered wrongly");

	property p_flush_busy;
		@(posedge clk) disable iff (sys_rst)
		s_cmd(ata_cmd_pkg::OP_FLUSH) |=> flush_req_q && busy && (state_q == FLUSH);
	endproperty
	a_flush_busy: assert property (p_flush_busy) else $error("Flush not started");

	property p_flush_hold;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FLUSH) |-> busy;
	endproperty
	a_flush_hold: assert property (p_flush_hold) else $error("BSY dropped in flush");

	property p_flush_fail;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FLUSH) && flush_done && flush_fail |=>
		tf_q.error[ata_cmd_pkg::ER_ABRT] && (tf_q.addr0 == $past(flush_addr[7:0]))
		&& (tf_q.device[3:0] == $past(flush_addr[27:24]));
	endproperty
	a_flush_fail: assert property (p_flush_fail) else $error("Flush failure wrong");

	property p_fault;
		@(posedge clk) disable iff (sys_rst)
		read_fails && dev_fault |=> tf_q.status[ata_cmd_pkg::ST_DF];
	endproperty
	a_fault: assert property (p_fault) else $error("DF not set");

endmodule

// ===== verif/media_flush_model.sv
// Media and write-cache responder on the far side of the command block
`timescale 1ns/10ps
module media_flush_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic media_req,
	input wire logic flush_req,
	input wire logic [7:0] delay,
	input wire logic [15:0] err_at,
	input wire ata_cmd_pkg::media_result_type err_res,
	input wire logic fl_fail,
	input wire logic [27:0] fl_addr,
	output logic media_done,
	output ata_cmd_pkg::media_result_type media_result,
	output logic flush_done,
	output logic flush_fail,
	output logic [27:0] flush_addr
);
	logic [15:0] seq_q;
	logic [7:0] wait_m_q;
	logic [7:0] wait_f_q;
	logic busy_m_q;
	logic busy_f_q;
	logic flip_q;
	ata_cmd_pkg::media_result_type res_q;

	// One answer per request after a settable wait; chosen sector may fail
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			seq_q <= '0;
			busy_m_q <= 1'b0;
			busy_f_q <= 1'b0;
			media_done <= 1'b0;
			flush_done <= 1'b0;
			flip_q <= 1'b0;
		end
		else
		begin
			media_done <= 1'b0;
			flush_done <= 1'b0;
			flip_q <= ~flip_q;
			if (media_req)
			begin
				busy_m_q <= 1'b1;
				wait_m_q <= delay;
				res_q <= (seq_q == err_at) ? err_res : '0;
				seq_q <= seq_q + 16'h0001;
			end
			else if (busy_m_q && wait_m_q == 8'h00)
			begin
				media_done <= 1'b1;
				busy_m_q <= 1'b0;
			end
			else if (busy_m_q)
				wait_m_q <= wait_m_q - 8'h01;
			if (flush_req)
			begin
				busy_f_q <= 1'b1;
				wait_f_q <= delay;
			end
			else if (busy_f_q && wait_f_q == 8'h00)
			begin
				flush_done <= 1'b1;
				busy_f_q <= 1'b0;
			end
			else if (busy_f_q)
				wait_f_q <= wait_f_q - 8'h01;
		end
	end

	// Outside a strobe the result lines toggle, so stale values are never trusted
	assign media_result = media_done ? res_q : {3{flip_q}};
	assign flush_fail = flush_done ? fl_fail : flip_q;
	assign flush_addr = flush_done ? fl_addr : {28{flip_q}};
endmodule

// ===== verif/ata_command_completion_tb.sv
// Self-checking bench for the ATA command completion block
`timescale 1ns/10ps
module ata_command_completion_tb;
	logic clk, sys_rst, reg_wr, udma_mode, dev_fault, media_req, media_to_host, media_done;
	logic flush_req, flush_done, flush_fail, sleep_mode, dma_active, fl_fail;
	logic [3:0] reg_sel;
	logic [7:0] reg_wdata, block_size, delay;
	logic [15:0] err_at;
	logic [27:0] media_addr, flush_addr, fl_addr, first_addr;
	ata_cmd_pkg::task_file_type tf;
	ata_cmd_pkg::media_result_type media_result, err_res;
	int n_req, n_base, miscompares, n_compared, drq_seen, host_seen, n_fl;

	ata_command_completion ata_command_completion_i (.clk(clk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .task_file(tf),
		.block_size(block_size), .sleep_mode(sleep_mode), .media_req(media_req),
		.media_addr(media_addr), .media_to_host(media_to_host), .media_done(media_done),
		.media_result(media_result), .udma_mode(udma_mode), .dev_fault(dev_fault),
		.flush_req(flush_req), .flush_done(flush_done), .flush_fail(flush_fail),
		.flush_addr(flush_addr), .dma_active(dma_active));
	media_flush_model media_flush_model_i (.clk(clk), .sys_rst(sys_rst),
		.media_req(media_req), .flush_req(flush_req), .delay(delay), .err_at(err_at),
		.err_res(err_res), .fl_fail(fl_fail), .fl_addr(fl_addr), .media_done(media_done),
		.media_result(media_result), .flush_done(flush_done), .flush_fail(flush_fail),
		.flush_addr(flush_addr));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Watch every media request and the data-request flag
	always @(posedge clk)
	begin
		if (tf.status[ata_cmd_pkg::ST_DRQ] !== 1'b0 && !sys_rst)
			drq_seen++;
		if (flush_req === 1'b1)
			n_fl++;
		if (media_req === 1'b1)
		begin
			if (n_req == n_base)
				first_addr = media_addr;
			if (media_to_host !== 1'b0)
				host_seen++;
			n_req++;
		end
	end

	task automatic chk(input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// One register write, strobe dropped at the next falling edge
	task automatic wr(input logic [3:0] sel, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_sel = sel;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 2000 && tf.status[ata_cmd_pkg::ST_BSY] !== 1'b0; i++)
			@(negedge clk);
		chk(1'b0, tf.status[ata_cmd_pkg::ST_BSY]);
	endtask

	// Loads the command block with DEV set and a marker nibble, then the opcode
	task automatic issue(input logic [7:0] op, input logic [7:0] cnt, input logic [27:0] a);
		wait_idle();
		chk(1'b1, tf.status[ata_cmd_pkg::ST_DRDY]);
		n_base = n_req;
		wr(ata_cmd_pkg::SEL_COUNT, cnt);
		wr(ata_cmd_pkg::SEL_ADDR0, a[7:0]);
		wr(ata_cmd_pkg::SEL_ADDR1, a[15:8]);
		wr(ata_cmd_pkg::SEL_ADDR2, a[23:16]);
		wr(ata_cmd_pkg::SEL_DEVICE, {4'h5, a[27:24]});
		wr(ata_cmd_pkg::SEL_COMMAND, op);
	endtask

	function automatic logic [7:0] st(input logic e, input logic df);
		st = 8'h00;
		st[ata_cmd_pkg::ST_DRDY] = 1'b1;
		st[ata_cmd_pkg::ST_DF] = df;
		st[ata_cmd_pkg::ST_ERR] = e;
	endfunction

	task automatic t_reset;
		chk(8'h40, tf.status);
		chk(8'h00, tf.error);
		chk(8'h01, block_size);
		chk(1'b0, sleep_mode);
		chk(40'h00_0000_0000, {tf.count, tf.addr0, tf.addr1, tf.addr2, tf.device});
		$display("test reset done");
	endtask

	task automatic t_verify;
		host_seen = 0;
		issue(ata_cmd_pkg::OP_READ_VERIFY, 8'h03, 28'hA1B_2C3D);
		wait_idle();
		chk(3, n_req - n_base);
		chk(28'hA1B_2C3D, first_addr);
		chk(28'hA1B_2C3F, media_addr);
		chk(0, host_seen);
		chk(0, drq_seen);
		chk(st(1'b0, 1'b0), tf.status);
		chk(8'h5A, tf.device);
		$display("test verify done");
	endtask

	task automatic t_dma_full;
		host_seen = 0;
		issue(ata_cmd_pkg::OP_READ_DMA, 8'h00, 28'h0FF_FF80);
		chk(1'b1, dma_active);
		wait_idle();
		chk(256, n_req - n_base);
		chk(256, host_seen);
		chk(28'h100_007F, media_addr);
		chk(st(1'b0, 1'b0), tf.status);
		chk(1'b0, dma_active);
		$display("test dma full run done");
	endtask

	// The third sector of 4 fails in several ways, then a CRC outside Ultra DMA, then a device
	// fault, which ends the read at its first sector with DF but no error bit
	task automatic t_errors;
		logic [7:0] ops[5] = '{8'h40, 8'h40, 8'hC8, 8'hC8, 8'h40};
		logic [2:0] res[5] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b000};
		logic [7:0] ex[5] = '{8'h40, 8'h10, 8'h80, 8'h00, 8'h00};
		logic ud[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		logic df[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		logic [27:0] fa[5] = '{28'h300_0100, 28'h300_0100, 28'h300_0100,
			28'h300_00FE, 28'h300_00FE};
		int nr[5] = '{3, 3, 3, 4, 1};
		for (int k = 0; k < 5; k++)
		begin
			@(negedge clk);
			udma_mode = ud[k];
			dev_fault = df[k];
			err_res = res[k];
			err_at = 16'(n_req + 2);
			issue(ops[k], 8'h04, 28'h300_00FE);
			wait_idle();
			chk(ex[k], tf.error);
			chk(st(ex[k] != 8'h00, df[k]), tf.status);
			chk({4'h5, fa[k]}, {tf.device, tf.addr2, tf.addr1, tf.addr0});
			chk(nr[k], n_req - n_base);
		end
		dev_fault = 1'b0;
		udma_mode = 1'b0;
		err_at = 16'hFFFF;
		$display("test read errors done");
	endtask

	// Block size: supported, zero, too large, then an opcode outside the set
	task automatic t_block;
		logic [7:0] ops[4] = '{8'hC6, 8'hC6, 8'hC6, 8'hC4};
		logic [7:0] cnt[4] = '{8'h01, 8'h00, 8'h02, 8'h01};
		logic [7:0] ex[4] = '{8'h00, 8'h00, 8'h04, 8'h04};
		for (int k = 0; k < 4; k++)
		begin
			issue(ops[k], cnt[k], 28'h000_0000);
			wait_idle();
			chk(ex[k], tf.error);
			chk(st(ex[k] != 8'h00, 1'b0), tf.status);
			chk(8'h01, block_size);
		end
		$display("test block size done");
	endtask

	task automatic t_flush;
		delay = 8'd20;
		issue(ata_cmd_pkg::OP_FLUSH, 8'h00, 28'h000_0012);
		repeat (10) @(negedge clk);
		chk(1'b1, tf.status[ata_cmd_pkg::ST_BSY]);
		wr(ata_cmd_pkg::SEL_ADDR0, 8'hEE);
		wait_idle();
		chk(st(1'b0, 1'b0), tf.status);
		chk(8'h12, tf.addr0);
		fl_fail = 1'b1;
		fl_addr = 28'h765_4321;
		issue(ata_cmd_pkg::OP_FLUSH, 8'h00, 28'h000_0011);
		wait_idle();
		chk(8'h04, tf.error);
		chk(st(1'b1, 1'b0), tf.status);
		chk(32'h5765_4321, {tf.device, tf.addr2, tf.addr1, tf.addr0});
		chk(2, n_fl);
		delay = 8'd0;
		$display("test flush done");
	endtask

	task automatic t_sleep;
		chk(1'b0, sleep_mode);
		issue(ata_cmd_pkg::OP_SLEEP, 8'h00, 28'h000_0000);
		wait_idle();
		chk(1'b1, sleep_mode);
		chk(st(1'b0, 1'b0), tf.status);
		$display("test sleep done");
	endtask

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog: the whole run needs under two thousand cycles
	initial
	begin
		#(25 * 20000);
		miscompares++;
		complete_run();
	end

	initial
	begin
		{reg_wr, udma_mode, dev_fault, fl_fail} = '0;
		{reg_sel, reg_wdata, delay, fl_addr} = '0;
		{n_req, n_base, miscompares, n_compared, drq_seen, host_seen, n_fl} = '0;
		err_res = '0;
		err_at = 16'hFFFF;
		sys_rst = 1'b1;
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_verify();
		t_dma_full();
		t_errors();
		t_block();
		t_flush();
		t_sleep();
		complete_run();
	end
endmodule
